// file: logic/serial_status_map.svh
// register offsets, field positions and reset values of the serial status block
`ifndef SERIAL_STATUS_MAP_SVH
`define SERIAL_STATUS_MAP_SVH
`define STATUS_OFFSET 4'h0
`define CONTROL_OFFSET 4'h4
`define RXDATA_OFFSET 4'h8
`define STATUS_RESET 8'h84
`define CONTROL_RESET 8'h00
`define BIT_TX_BUFFER_EMPTY_FLAG_POS 7
`define BIT_RX_BUFFER_FULL_FLAG_POS 6
`define BIT_OVR_POS 5
`define BIT_FRM_POS 4
`define BIT_PAR_POS 3
`define BIT_TX_END_FLAG_POS 2
`define BIT_RXMP_POS 1
`define BIT_TXMP_POS 0
`define CTL_TXEN_POS 0
`define CTL_RXEN_POS 1
`define CTL_SYNC_POS 2
`define CTL_MPFMT_POS 3
`define CTL_ODD_POS 4
`define CTL_FILT_POS 5
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// file: logic/serial_status_pkg.sv
// types shared by the serial status block
package serial_status_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic mp_bit;
    logic parity_bit;
    logic stop_bit;
  } rx_char_s;
  typedef enum logic [1:0] {
    wr_idle,
    wr_resp
  } wr_state_e;
endpackage

// file: logic/serial_status_flags.sv
// status flags, control bits and receive buffer of the serial channel, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "serial_status_map.svh"
module serial_status_flags #(
  // bus and character widths
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32,
  parameter int CHAR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit engine
  input wire logic tx_load,
  input wire logic tx_last_bit,
  output logic tx_data_ready,
  output logic tx_multiproc_bit,
  output logic tx_halt,
  // receive engine
  input wire serial_status_pkg::rx_char_s rx_char,
  output logic rx_halt,
  output logic [CHAR_W-1:0] rx_buffer,
  // dma controller
  input wire logic dma_rx_read
);
  import serial_status_pkg::*;

  logic tx_buffer_empty_flag;
  logic rx_buffer_full_flag;
  logic overrun_flag;
  logic framing_flag;
  logic parity_flag;
  logic tx_end_flag;
  logic rx_multiproc_bit;
  logic [7:0] serial_control;
  // one arming bit per clearable flag
  logic [4:0] seen_one;
  logic init;
  logic tx_enable;
  logic rx_enable;
  logic sync_mode;
  logic mp_format;
  logic odd_parity;
  logic multiproc_filter_enable;
  logic [7:0] status_view;
  wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic wr_fire;
  logic st_wr;
  logic ctl_wr;
  logic wr_bad;
  logic [4:0] clr_req;
  logic rx_accept;
  logic rx_fer;
  logic rx_per;
  logic rx_ovr;
  logic rx_clean;
  logic any_err;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;

  assign init = !aresetn || standby;
  assign tx_enable = serial_control[`CTL_TXEN_POS];
  assign rx_enable = serial_control[`CTL_RXEN_POS];
  assign sync_mode = serial_control[`CTL_SYNC_POS];
  assign mp_format = serial_control[`CTL_MPFMT_POS];
  assign odd_parity = serial_control[`CTL_ODD_POS];
  assign multiproc_filter_enable = serial_control[`CTL_FILT_POS];

  assign status_view = {tx_buffer_empty_flag, rx_buffer_full_flag, overrun_flag,
                        framing_flag, parity_flag, tx_end_flag, rx_multiproc_bit,
                        tx_multiproc_bit};

  // write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held && wr_state == wr_idle;
  assign s_axi_wready = !w_held && wr_state == wr_idle;
  // address half, held until the data half has arrived too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end
  // data half, held until the address half has arrived too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end
  assign wr_fire = aw_held && w_held && wr_state == wr_idle;
  assign st_wr = wr_fire && aw_addr == `STATUS_OFFSET && w_strb[0];
  assign ctl_wr = wr_fire && aw_addr == `CONTROL_OFFSET && w_strb[0];
  assign wr_bad = aw_addr != `STATUS_OFFSET && aw_addr != `CONTROL_OFFSET
                  && aw_addr != `RXDATA_OFFSET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= wr_idle;
    end else begin
      case (wr_state)
        wr_idle: begin
          if (wr_fire) begin
            wr_state <= wr_resp;
          end
        end
        wr_resp: begin
          if (s_axi_bready) begin
            wr_state <= wr_idle;
          end
        end
        default: wr_state <= wr_idle;
      endcase
    end
  end
  // response stands until the master takes it; no new write meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? `AXI_SLVERR : `AXI_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle to data
  assign s_axi_arready = !s_axi_rvalid;
  // decode kept apart so the data flop only picks up a finished word
  always_comb begin
    next_rdata = '0;
    next_rresp = `AXI_OKAY;
    case (s_axi_araddr)
      `STATUS_OFFSET: next_rdata = DATA_W'(status_view);
      `CONTROL_OFFSET: next_rdata = DATA_W'(serial_control);
      `RXDATA_OFFSET: next_rdata = DATA_W'(rx_buffer);
      default: next_rresp = `AXI_SLVERR;
    endcase
  end
  // the status word is sampled at the same edge that arms its flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // arm each clearable flag once software has seen it as one
  wire status_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `STATUS_OFFSET;
  wire [4:0] clearable = {tx_buffer_empty_flag, rx_buffer_full_flag, overrun_flag,
                          framing_flag, parity_flag};
  always_ff @(posedge aclk) begin
    if (init) begin
      seen_one <= 5'h0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (clr_req[i] || !clearable[i]) begin
          seen_one[i] <= 1'b0;
        end else if (status_read && clearable[i]) begin
          seen_one[i] <= 1'b1;
        end
      end
    end
  end
  // writes of one ignored; zero clears only an armed flag
  assign clr_req = seen_one & ~w_data[`BIT_TX_BUFFER_EMPTY_FLAG_POS:`BIT_PAR_POS] & {5{st_wr}};

  // control bits; filter enable also cleared by hardware on an MP-one character
  always_ff @(posedge aclk) begin
    if (init) begin
      serial_control <= `CONTROL_RESET;
    end else begin
      if (ctl_wr) begin
        serial_control <= w_data[7:0];
      end
      if (rx_accept && rx_char.mp_bit && multiproc_filter_enable) begin
        serial_control[`CTL_FILT_POS] <= 1'b0;
      end
    end
  end

  // receive decode
  assign any_err = overrun_flag || framing_flag || parity_flag;
  assign rx_halt = any_err;
  assign tx_halt = any_err && sync_mode;
  // filtered characters are dropped entirely until one carries MP bit one
  assign rx_accept = rx_char.valid && rx_enable && !any_err
                     && !(mp_format && !sync_mode && multiproc_filter_enable
                          && !rx_char.mp_bit);
  // only the first stop bit reaches this block
  assign rx_fer = !sync_mode && !rx_char.stop_bit;
  assign rx_per = !sync_mode && !mp_format
                  && ((^rx_char.data ^ rx_char.parity_bit) != odd_parity);
  assign rx_ovr = rx_buffer_full_flag;
  assign rx_clean = rx_accept && !rx_ovr && !rx_fer && !rx_per;

  // buffer survives standby; only a chip reset empties it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buffer <= '0;
    end else if (rx_accept && !rx_ovr) begin
      rx_buffer <= rx_char.data;
    end
  end

  // receive-full: set beats clear
  always_ff @(posedge aclk) begin
    if (init) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (rx_clean) begin
      rx_buffer_full_flag <= 1'b1;
    end else if (clr_req[3] || dma_rx_read) begin
      rx_buffer_full_flag <= 1'b0;
    end
  end

  // error flags: a new character beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (init) begin
      overrun_flag <= 1'b0;
    end else if (rx_accept && rx_ovr) begin
      overrun_flag <= 1'b1;
    end else if (clr_req[2]) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      framing_flag <= 1'b0;
    end else if (rx_accept && !rx_ovr && rx_fer) begin
      framing_flag <= 1'b1;
    end else if (clr_req[1]) begin
      framing_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      parity_flag <= 1'b0;
    end else if (rx_accept && !rx_ovr && rx_per) begin
      parity_flag <= 1'b1;
    end else if (clr_req[0]) begin
      parity_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      rx_multiproc_bit <= 1'b0;
    end else if (rx_accept && mp_format && !sync_mode) begin
      rx_multiproc_bit <= rx_char.mp_bit;
    end
  end

  // transmit side
  // disable or load sets the flag even against a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (init) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (!tx_enable || tx_load) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (clr_req[4]) begin
      tx_buffer_empty_flag <= 1'b0;
    end
  end
  assign tx_data_ready = !tx_buffer_empty_flag && tx_enable && !tx_halt;

  always_ff @(posedge aclk) begin
    if (init) begin
      tx_end_flag <= 1'b1;
    end else if (!tx_enable || (tx_last_bit && tx_buffer_empty_flag)) begin
      tx_end_flag <= 1'b1;
    end else if (clr_req[4]) begin
      tx_end_flag <= 1'b0;
    end
  end

  // engine uses this only in async multiprocessor format while sending
  always_ff @(posedge aclk) begin
    if (init) begin
      tx_multiproc_bit <= 1'b0;
    end else if (st_wr) begin
      tx_multiproc_bit <= w_data[`BIT_TXMP_POS];
    end
  end
endmodule
`default_nettype wire

// file: tb/serial_peer.sv
// remote engine model: received characters and transmit pacing
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // clock
  input wire logic aclk,
  // engine side
  input wire logic tx_data_ready,
  output serial_status_pkg::rx_char_s rx_char,
  output logic tx_load,
  output logic tx_last_bit
);
  int gap = 20;
  initial {rx_char, tx_load, tx_last_bit} = '0;
  // idle data shows the inverse, so a stale byte cannot pass
  task automatic send(input logic [7:0] d, input logic mp, par, stp);
    @(posedge aclk);
    rx_char <= {1'b1, d, mp, par, stp};
    @(posedge aclk);
    rx_char <= {1'b0, ~d, mp, par, stp};
  endtask
  // slow pacing leaves the bench time to read the cleared flags
  always @(posedge aclk) if (tx_data_ready === 1'b1) begin
    repeat (gap) @(posedge aclk);
    tx_load <= 1'b1;
    @(posedge aclk);
    tx_load <= 1'b0;
    repeat (gap) @(posedge aclk);
    tx_last_bit <= 1'b1;
    @(posedge aclk);
    tx_last_bit <= 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/status_chk_asserts.sv
// port checks for the serial status block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module status_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  // observed ports
  input wire logic s_axi_bvalid,
  input wire logic tx_load,
  input wire logic tx_data_ready,
  input wire logic tx_halt,
  input wire serial_status_pkg::rx_char_s rx_char,
  input wire logic rx_halt,
  input wire logic [7:0] rx_buffer
);
  import serial_status_pkg::*;
  logic buf_src;
  assign buf_src = rx_char.valid | standby | !aresetn;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_done; $rose(s_axi_bvalid); endsequence
  // error flags only drop through a register write, standby or reset
  sequence sw_cause; wr_done or $past(standby) or $past(!aresetn); endsequence
  standby_init_a: assert property (standby |=> !rx_halt && !tx_data_ready)
    else $error("standby left flags set");
  load_empty_a: assert property (tx_load |=> !tx_data_ready)
    else $error("load did not empty buffer");
  offer_cause_a: assert property ($rose(tx_data_ready) |-> wr_done)
    else $error("data offered without write");
  halt_lift_a: assert property ($fell(rx_halt) |-> sw_cause)
    else $error("error flag dropped by itself");
  halt_keep_a: assert property (rx_halt && !standby |=> $stable(rx_buffer))
    else $error("buffer changed while halted");
  sync_halt_a: assert property (tx_halt |-> rx_halt && !tx_data_ready)
    else $error("transmit halt without error");
  tx_lift_a: assert property ($fell(tx_halt) |-> sw_cause)
    else $error("transmit halt dropped by itself");
  buf_cause_a: assert property (!$stable(rx_buffer) |-> $past(buf_src))
    else $error("buffer changed without character");
endmodule
bind serial_status_flags status_chk u_status_chk (.aclk, .aresetn, .standby, .s_axi_bvalid,
  .tx_load, .tx_data_ready, .tx_halt, .rx_char, .rx_halt, .rx_buffer);
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the serial status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serial_status_pkg::*;
  logic aclk, aresetn, standby, dma_rx_read, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tx_load, tx_last_bit, tx_data_ready;
  logic tx_multiproc_bit, tx_halt, rx_halt;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] rx_buffer;
  rx_char_s rx_char;
  int err_count = 0;
  int checks_done = 0;
  serial_status_flags u_serial_status_flags (.aclk, .aresetn, .standby, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_load, .tx_last_bit,
    .tx_data_ready, .tx_multiproc_bit, .tx_halt, .rx_char, .rx_halt, .rx_buffer, .dma_rx_read);
  serial_peer u_serial_peer (.aclk, .tx_data_ready, .rx_char, .tx_load, .tx_last_bit);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // readys are looked at mid-cycle; inputs only move at rising edges
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do @(negedge aclk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    r = s_axi_rresp;
    chk(s_axi_rdata, e);
    @(posedge aclk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    complete_run();
  end
  initial begin
    {aresetn, standby, dma_rx_read, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(4'h0, 8'h7F);
    rd(4'h0, 32'h85);
    chk(tx_multiproc_bit, 32'h1);
    rd(4'hC, 32'h0);
    chk(r, 32'h2);
    wr(4'hC, 8'hFF);
    chk(r, 32'h2);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h0, 32'h00);
    chk(tx_data_ready, 32'h1);
    for (int i = 0; i < 100 && tx_last_bit !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
    rd(4'h0, 32'h84);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    rd(4'h0, 32'h84);
    wr(4'h4, 8'h06);
    u_serial_peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
    rd(4'h0, 32'hC4);
    u_serial_peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    rd(4'h0, 32'hE4);
    chk(tx_halt, 32'h1);
    u_serial_peer.send(8'h11, 1'b0, 1'b0, 1'b1);
    rd(4'h8, 32'h5A);
    wr(4'h4, 8'h00);
    rd(4'h0, 32'hE4);
    wr(4'h0, 8'h84);
    rd(4'h0, 32'h84);
    wr(4'h4, 8'h02);
    u_serial_peer.send(8'hA5, 1'b0, 1'b1, 1'b0);
    rd(4'h0, 32'h9C);
    rd(4'h8, 32'hA5);
    wr(4'h0, 8'h84);
    wr(4'h4, 8'h12);
    u_serial_peer.send(8'h01, 1'b0, 1'b0, 1'b1);
    rd(4'h0, 32'hC4);
    dma_rx_read <= 1'b1;
    @(posedge aclk);
    dma_rx_read <= 1'b0;
    rd(4'h0, 32'h84);
    wr(4'h4, 8'h2A);
    u_serial_peer.send(8'h10, 1'b0, 1'b0, 1'b1);
    rd(4'h8, 32'h01);
    u_serial_peer.send(8'h20, 1'b1, 1'b0, 1'b1);
    rd(4'h4, 32'h0A);
    wr(4'h4, 8'h08);
    rd(4'h0, 32'hC6);
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
    rd(4'h0, 32'h84);
    rd(4'h4, 32'h00);
    complete_run();
  end
endmodule
`default_nettype wire
